// file: pkg/diag_consts.svh
// Register map, field positions and counts of the diagnostic counters and self-test block.
// Assumes a 16-bit management register space with 5-bit word addresses.
`ifndef DIAG_CONSTS_SVH
`define DIAG_CONSTS_SVH

// Register word addresses
`define ADDR_IRQ_STATUS_ONE 5'h12
`define ADDR_IRQ_STATUS_TWO 5'h13
`define ADDR_FALSE_CARRIER 5'h14
`define ADDR_RX_ERROR 5'h15
`define ADDR_SELFTEST 5'h16

// Interrupt register fields
`define BIT_PEND_FC 9
`define BIT_PEND_RE 8
`define BIT_EN_FC 1
`define BIT_EN_RE 0
`define BIT_PEND_JAB 8
`define BIT_EN_JAB 0

// Self-test control fields
`define BIT_ERR_MODE 14
`define BIT_CHK_EN 13
`define BIT_GEN_EN 12
`define BIT_LOCKED 11
`define BIT_SYNC_LOSS 10
`define BIT_GEN_ACTIVE 9

// Counter limits
`define FC_MAX 8'hFF
`define FC_HALF 8'h7F
`define RE_MAX 16'hFFFF
`define RE_HALF 16'h007F
`define BIST_ERR_MAX 8'hFF

// PRBS checker lock and loss thresholds, and the seed of both LFSRs
`define LOCK_MATCHES 4'hF
`define LOSS_MISSES 2'h3
`define LFSR_SEED 7'h7F

`endif

// file: pkg/diag_pkg.sv
// Types shared by the diagnostic counters and self-test block.
// Assumes diag_consts.svh is not needed here; widths are fixed.
package diag_pkg;

	// Management register port request
	typedef struct packed {
		logic [4:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	// Receive-side event inputs
	typedef struct packed {
		logic false_carrier;
		logic rx_dv;
		logic rx_invalid_sym;
		logic mii_loopback;
		logic jabber;
	} rx_evt_t;

	// All state of the block
	typedef struct packed {
		logic [15:0] rdata;
		logic irq;
		logic [7:0] fc_cnt;
		logic [15:0] re_cnt;
		logic pend_fc;
		logic pend_re;
		logic pend_jab;
		logic en_fc;
		logic en_re;
		logic en_jab;
		logic err_mode;
		logic chk_en;
		logic gen_en;
		logic locked;
		logic sync_loss;
		logic gen_active;
		logic [6:0] chk_lfsr;
		logic [3:0] match_cnt;
		logic [1:0] miss_cnt;
		logic [7:0] bist_err;
		logic err_wrap;
		logic [6:0] gen_lfsr;
		logic tx_bit;
		logic tx_valid;
	} state_t;

endpackage

// file: design/diag_counters.sv
// Error counters, interrupt flags and PRBS self-test logic of a 10/100 PHY.
// Assumes all inputs are synchronous to clock; register reads return data the next cycle.
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "diag_consts.svh"

module diag_counters (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Management register port
	input wire diag_pkg::reg_req_t req,
	output logic [15:0] reg_rdata,
	// Receive path events
	input wire diag_pkg::rx_evt_t evt,
	input wire logic prbs_rx_bit,
	input wire logic prbs_rx_valid,
	// Outputs
	output logic irq,
	output logic bist_err_wrap,
	output logic tx_prbs_bit,
	output logic tx_prbs_valid
);

	diag_pkg::state_t st_ff;
	diag_pkg::state_t nxt_st;

	// Address match, used by both read and write decoding
	function automatic logic hit(input diag_pkg::reg_req_t r, input logic [4:0] a);
		hit = r.addr == a;
	endfunction

	// Next PRBS value, x^7 + x^6 + 1
	function automatic logic prbs_fb(input logic [6:0] s);
		prbs_fb = s[6] ^ s[5];
	endfunction

	logic rd_fc;
	logic rd_re;
	logic rd_st;
	logic re_evt;
	logic exp_bit;
	logic mismatch;

	// Decoded strobes and checker compare
	always_comb begin
		rd_fc = req.rd && hit(req, `ADDR_FALSE_CARRIER);
		rd_re = req.rd && hit(req, `ADDR_RX_ERROR);
		rd_st = req.rd && hit(req, `ADDR_SELFTEST);
		re_evt = evt.rx_dv && evt.rx_invalid_sym && !evt.mii_loopback;
		exp_bit = prbs_fb(st_ff.chk_lfsr);
		mismatch = prbs_rx_bit != exp_bit;
	end

	// Next state of the whole block
	always_comb begin
		logic fc_half;
		logic re_half;
		logic [15:0] rd;
		nxt_st = st_ff;
		fc_half = 1'b0;
		re_half = 1'b0;
		rd = 16'h0000;
		nxt_st.err_wrap = 1'b0;

		// False-carrier counter; a read clears, a coincident event counts from one
		if (rd_fc) begin
			nxt_st.fc_cnt = evt.false_carrier ? 8'h01 : 8'h00;
		end else if (evt.false_carrier && st_ff.fc_cnt != `FC_MAX) begin
			nxt_st.fc_cnt = st_ff.fc_cnt + 8'h01;
			fc_half = st_ff.fc_cnt == `FC_HALF;
		end

		// Receive-error counter, same clearing scheme
		if (rd_re) begin
			nxt_st.re_cnt = re_evt ? 16'h0001 : 16'h0000;
		end else if (re_evt && st_ff.re_cnt != `RE_MAX) begin
			nxt_st.re_cnt = st_ff.re_cnt + 16'h0001;
			re_half = st_ff.re_cnt == `RE_HALF;
		end

		// Register writes: enables and modes, write-one clears pending flags
		if (req.wr && hit(req, `ADDR_IRQ_STATUS_ONE)) begin
			nxt_st.en_fc = req.wdata[`BIT_EN_FC];
			nxt_st.en_re = req.wdata[`BIT_EN_RE];
			if (req.wdata[`BIT_PEND_FC]) nxt_st.pend_fc = 1'b0;
			if (req.wdata[`BIT_PEND_RE]) nxt_st.pend_re = 1'b0;
		end
		if (req.wr && hit(req, `ADDR_IRQ_STATUS_TWO)) begin
			nxt_st.en_jab = req.wdata[`BIT_EN_JAB];
			if (req.wdata[`BIT_PEND_JAB]) nxt_st.pend_jab = 1'b0;
		end
		if (req.wr && hit(req, `ADDR_SELFTEST)) begin
			nxt_st.err_mode = req.wdata[`BIT_ERR_MODE];
			nxt_st.chk_en = req.wdata[`BIT_CHK_EN];
			nxt_st.gen_en = req.wdata[`BIT_GEN_EN];
		end

		// Hardware sets placed after clears so an event in the clear cycle survives
		if (fc_half) nxt_st.pend_fc = 1'b1;
		if (re_half) nxt_st.pend_re = 1'b1;
		if (evt.jabber) nxt_st.pend_jab = 1'b1;

		// Reading the self-test register releases the latched sync loss
		if (rd_st) nxt_st.sync_loss = 1'b0;

		// PRBS checker: self-synchronising while hunting, free-running once locked
		if (!st_ff.chk_en) begin
			nxt_st.locked = 1'b0;
			nxt_st.match_cnt = 4'h0;
			nxt_st.miss_cnt = 2'h0;
		end else if (prbs_rx_valid) begin
			if (!st_ff.locked) begin
				nxt_st.chk_lfsr = {st_ff.chk_lfsr[5:0], prbs_rx_bit};
				nxt_st.match_cnt = mismatch ? 4'h0 : st_ff.match_cnt + 4'h1;
				if (!mismatch && st_ff.match_cnt == `LOCK_MATCHES - 4'h1)
					nxt_st.locked = 1'b1;
			end else begin
				nxt_st.chk_lfsr = {st_ff.chk_lfsr[5:0], exp_bit};
				if (mismatch) begin
					nxt_st.miss_cnt = st_ff.miss_cnt + 2'h1;
					if (st_ff.bist_err != `BIST_ERR_MAX) begin
						nxt_st.bist_err = st_ff.bist_err + 8'h01;
					end else if (st_ff.err_mode) begin
						nxt_st.bist_err = 8'h00;
						nxt_st.err_wrap = 1'b1;
					end // Single mode holds at maximum
					if (st_ff.miss_cnt == `LOSS_MISSES - 2'h1) begin
						nxt_st.locked = 1'b0;
						nxt_st.match_cnt = 4'h0;
						nxt_st.miss_cnt = 2'h0;
						nxt_st.sync_loss = 1'b1;
					end
				end else begin
					nxt_st.miss_cnt = 2'h0;
				end
			end
		end

		// PRBS generator; bits stream out continuously while enabled
		nxt_st.gen_active = st_ff.gen_en;
		nxt_st.tx_valid = st_ff.gen_en;
		if (st_ff.gen_en) begin
			nxt_st.gen_lfsr = {st_ff.gen_lfsr[5:0], prbs_fb(st_ff.gen_lfsr)};
			nxt_st.tx_bit = prbs_fb(st_ff.gen_lfsr);
		end else begin
			nxt_st.tx_bit = 1'b0;
		end

		// Read data shows the value before any clear of this cycle
		if (req.rd) begin
			case (req.addr)
				`ADDR_IRQ_STATUS_ONE: begin
					rd[`BIT_PEND_FC] = st_ff.pend_fc;
					rd[`BIT_PEND_RE] = st_ff.pend_re;
					rd[`BIT_EN_FC] = st_ff.en_fc;
					rd[`BIT_EN_RE] = st_ff.en_re;
				end
				`ADDR_IRQ_STATUS_TWO: begin
					rd[`BIT_PEND_JAB] = st_ff.pend_jab;
					rd[`BIT_EN_JAB] = st_ff.en_jab;
				end
				`ADDR_FALSE_CARRIER: begin
					rd = {8'h00, st_ff.fc_cnt};
				end
				`ADDR_RX_ERROR: begin
					rd = st_ff.re_cnt;
				end
				`ADDR_SELFTEST: begin
					rd[`BIT_ERR_MODE] = st_ff.err_mode;
					rd[`BIT_CHK_EN] = st_ff.chk_en;
					rd[`BIT_GEN_EN] = st_ff.gen_en;
					rd[`BIT_LOCKED] = st_ff.locked;
					rd[`BIT_SYNC_LOSS] = st_ff.sync_loss;
					rd[`BIT_GEN_ACTIVE] = st_ff.gen_active;
				end
				default: begin
					rd = 16'h0000;
				end
			endcase
		end
		nxt_st.rdata = rd;

		// Interrupt follows the next flags so it lines up with them
		nxt_st.irq = (nxt_st.pend_fc && nxt_st.en_fc) || (nxt_st.pend_re && nxt_st.en_re)
			|| (nxt_st.pend_jab && nxt_st.en_jab);
	end

	// State register; reset clears everything except the two LFSRs, which load the seed
	always_ff @(posedge clock) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.chk_lfsr <= `LFSR_SEED;
			st_ff.gen_lfsr <= `LFSR_SEED;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs straight from the state register
	assign reg_rdata = st_ff.rdata;
	assign irq = st_ff.irq;
	assign bist_err_wrap = st_ff.err_wrap;
	assign tx_prbs_bit = st_ff.tx_bit;
	assign tx_prbs_valid = st_ff.tx_valid;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence fc_count_step;
		evt.false_carrier && !rd_fc && st_ff.fc_cnt != 8'hFF;
	endsequence

	sequence re_half_cross;
		re_evt && !rd_re && st_ff.re_cnt == 16'h007F;
	endsequence

	sequence miss_at_max(logic mode);
		st_ff.chk_en && st_ff.locked && prbs_rx_valid && mismatch
			&& st_ff.bist_err == 8'hFF && st_ff.err_mode == mode;
	endsequence

	chk_fc_increment: assert property (fc_count_step |=> st_ff.fc_cnt == $past(st_ff.fc_cnt) + 8'h01)
		else $error("false carrier count did not step");
	chk_fc_saturate: assert property (st_ff.fc_cnt == 8'hFF && !rd_fc |=> st_ff.fc_cnt == 8'hFF)
		else $error("false carrier count left saturation");
	chk_fc_half: assert property (fc_count_step ##0 st_ff.fc_cnt == 8'h7F |=> st_ff.pend_fc)
		else $error("false carrier half-full flag missing");
	chk_read_clear: assert property (rd_fc && !evt.false_carrier
		|=> st_ff.fc_cnt == 8'h00 && reg_rdata == {8'h00, $past(st_ff.fc_cnt)})
		else $error("false carrier read did not clear");
	chk_read_restart: assert property (rd_re && re_evt |=> st_ff.re_cnt == 16'h0001)
		else $error("coincident error lost on read");
	chk_rx_only_valid: assert property (!rd_re && !(evt.rx_dv && evt.rx_invalid_sym)
		|=> $stable(st_ff.re_cnt))
		else $error("receive error counted without cause");
	chk_rx_loopback: assert property (evt.mii_loopback && !rd_re |=> $stable(st_ff.re_cnt))
		else $error("receive error counted in loopback");
	chk_rx_saturate: assert property (st_ff.re_cnt == 16'hFFFF && !rd_re
		|=> st_ff.re_cnt == 16'hFFFF)
		else $error("receive error count left saturation");
	chk_re_half: assert property (re_half_cross |=> st_ff.pend_re && st_ff.re_cnt == 16'h0080)
		else $error("receive error half-full flag missing");
	chk_wrap_pulse: assert property (miss_at_max(1'b1) |=> bist_err_wrap && st_ff.bist_err == 8'h00
		##1 !bist_err_wrap)
		else $error("continuous mode wrap wrong");
	chk_single_stop: assert property (miss_at_max(1'b0) |=> st_ff.bist_err == 8'hFF && !bist_err_wrap)
		else $error("single mode did not stop");
	chk_checker_off: assert property (!st_ff.chk_en |=> !st_ff.locked)
		else $error("checker locked while disabled");
	chk_gen_follow: assert property ($rose(st_ff.gen_en) |=> tx_prbs_valid && st_ff.gen_active)
		else $error("generator did not start");
	chk_lock_read: assert property (rd_st |=> reg_rdata[11] == $past(st_ff.locked))
		else $error("lock bit read wrong");
	chk_loss_latch: assert property (st_ff.sync_loss && !rd_st |=> st_ff.sync_loss)
		else $error("sync loss did not hold");
	chk_irq_gate: assert property (st_ff.pend_jab && st_ff.en_jab |-> irq)
		else $error("enabled pending flag without interrupt");

	// A pending flag only drops on a write of one to its own bit
	sequence pend_fc_kept;
		st_ff.pend_fc && !(req.wr && req.addr == `ADDR_IRQ_STATUS_ONE
			&& req.wdata[`BIT_PEND_FC]);
	endsequence

	sequence pend_re_kept;
		st_ff.pend_re && !(req.wr && req.addr == `ADDR_IRQ_STATUS_ONE
			&& req.wdata[`BIT_PEND_RE]);
	endsequence

	// Counting and clearing of the two error counters
	chk_fc_no_cause: assert property (!evt.false_carrier && !rd_fc
		|=> $stable(st_ff.fc_cnt))
		else $error("false carrier count moved without event");
	chk_fc_high_byte: assert property (rd_fc
		|=> reg_rdata[15:8] == 8'h00)
		else $error("false carrier upper byte not zero");
	chk_fc_restart: assert property (rd_fc && evt.false_carrier
		|=> st_ff.fc_cnt == 8'h01)
		else $error("false carrier lost on read");
	chk_re_increment: assert property (re_evt && !rd_re && st_ff.re_cnt != 16'hFFFF
		|=> st_ff.re_cnt == $past(st_ff.re_cnt) + 16'h0001)
		else $error("receive error count did not step");
	chk_re_read_clear: assert property (rd_re && !re_evt
		|=> st_ff.re_cnt == 16'h0000 && reg_rdata == $past(st_ff.re_cnt))
		else $error("receive error read did not clear");

	// Pending flags and the interrupt level; the level is registered from the next flags
	chk_pend_fc_hold: assert property (pend_fc_kept
		|=> st_ff.pend_fc)
		else $error("false carrier pending flag dropped");
	chk_pend_re_hold: assert property (pend_re_kept
		|=> st_ff.pend_re)
		else $error("receive error pending flag dropped");
	chk_irq_fc: assert property (st_ff.pend_fc && st_ff.en_fc
		|-> irq)
		else $error("false carrier interrupt missing");
	chk_irq_re: assert property (st_ff.pend_re && st_ff.en_re
		|-> irq)
		else $error("receive error interrupt missing");
	chk_irq_quiet: assert property (!(st_ff.pend_fc && st_ff.en_fc)
		&& !(st_ff.pend_re && st_ff.en_re) && !(st_ff.pend_jab && st_ff.en_jab) |-> !irq)
		else $error("interrupt without an enabled pending flag");
	chk_jab_enable_write: assert property (req.wr && req.addr == `ADDR_IRQ_STATUS_TWO
		|=> st_ff.en_jab == $past(req.wdata[`BIT_EN_JAB]))
		else $error("jabber enable not written");

	// Self-test checker, error counter modes and generator status
	chk_checker_idle: assert property (!st_ff.chk_en
		|=> $stable(st_ff.bist_err))
		else $error("self test errors counted while disabled");
	chk_lock_count: assert property ($rose(st_ff.locked)
		|-> $past(st_ff.match_cnt) == 4'hE)
		else $error("checker locked too early");
	chk_loss_misses: assert property ($rose(st_ff.sync_loss)
		|-> $past(st_ff.miss_cnt) == 2'h2 && !st_ff.locked)
		else $error("sync loss without three misses");
	chk_loss_clear: assert property (rd_st && !st_ff.locked
		|=> !st_ff.sync_loss)
		else $error("sync loss survived its read");
	chk_mode_write: assert property (req.wr && req.addr == `ADDR_SELFTEST
		|=> st_ff.err_mode == $past(req.wdata[`BIT_ERR_MODE]))
		else $error("error counter mode not written");
	chk_wrap_only_max: assert property (bist_err_wrap
		|-> $past(st_ff.bist_err) == 8'hFF && $past(st_ff.err_mode))
		else $error("wrap pulse away from maximum");
	chk_single_hold: assert property (st_ff.bist_err == 8'hFF && !st_ff.err_mode
		|=> st_ff.bist_err == 8'hFF)
		else $error("single mode error count moved");
	chk_gen_running: assert property (st_ff.gen_en
		|=> tx_prbs_valid && st_ff.gen_active)
		else $error("generator not running while enabled");
	chk_gen_stop: assert property (!st_ff.gen_en
		|=> !tx_prbs_valid && !st_ff.gen_active)
		else $error("generator running while disabled");

endmodule

// file: tb/testbench.sv
// Self-checking bench for the diagnostic counters and PRBS self-test logic.
// Assumes the design's own assertions run alongside; generator output loops to the checker.
`timescale 1ns/1ns

module testbench;
	typedef struct packed {logic [4:0] a; logic [15:0] w; logic [15:0] e;} row_t;
	logic clock = 1'b0;
	logic rst = 1'b1;
	diag_pkg::reg_req_t req = '0;
	diag_pkg::rx_evt_t evt = '0;
	logic prbs_rx_bit = 1'b0;
	logic prbs_rx_valid = 1'b0;
	logic [15:0] reg_rdata;
	logic irq;
	logic bist_err_wrap;
	logic tx_prbs_bit;
	logic tx_prbs_valid;
	logic feed = 1'b0;
	logic flip = 1'b0;
	logic sparse = 1'b0;
	int miscompares = 0;
	int samples_checked = 0;
	int cycles = 0;
	int wraps = 0;
	int w0;
	row_t rows [8];

	diag_counters dut_u (.clock(clock), .rst(rst), .req(req), .reg_rdata(reg_rdata),
		.evt(evt), .prbs_rx_bit(prbs_rx_bit), .prbs_rx_valid(prbs_rx_valid), .irq(irq),
		.bist_err_wrap(bist_err_wrap), .tx_prbs_bit(tx_prbs_bit),
		.tx_prbs_valid(tx_prbs_valid));

	always #2 clock = ~clock;

	// Loopback with optional corruption; a hung run is cut at the cycle ceiling
	always @(posedge clock) begin
		cycles <= cycles + 1;
		prbs_rx_bit <= tx_prbs_bit ^ flip ^ (sparse && cycles[3:0] == 4'h0);
		prbs_rx_valid <= tx_prbs_valid & feed;
		if (bist_err_wrap === 1'b1) wraps <= wraps + 1;
		if (cycles == 95000) begin
			miscompares = miscompares + 1;
			test_done();
		end
	end

	task check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", n, exp, seen);
		end
	endtask

	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		req.addr <= a;
		req.wdata <= d;
		req.wr <= 1'b1;
		@(posedge clock);
		req.wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task expect_reg(input string n, input logic [4:0] a, input logic [15:0] e);
		@(posedge clock);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge clock);
		req.rd <= 1'b0;
		#1 check(n, reg_rdata, e);
	endtask

	// Bits: false carrier, data valid, invalid symbol, loopback, jabber
	task pulse(input int n, input logic [4:0] m);
		repeat (n) begin
			@(posedge clock);
			evt <= diag_pkg::rx_evt_t'(m);
		end
		@(posedge clock);
		evt <= '0;
	endtask

	task idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task test_done;
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		rows = '{'{5'h12, 16'h0003, 16'h0003}, '{5'h12, 16'h0000, 16'h0000},
			'{5'h13, 16'h0001, 16'h0001}, '{5'h13, 16'h0000, 16'h0000},
			'{5'h16, 16'h7000, 16'h7200}, '{5'h16, 16'h0E00, 16'h0000},
			'{5'h14, 16'hFFFF, 16'h0000}, '{5'h1F, 16'hFFFF, 16'h0000}};
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		for (int i = 18; i < 23; i++) expect_reg("reset", 5'(i), 16'h0000);
		$display("reset done");
		// Write, let status settle, read back
		for (int i = 0; i < 8; i++) begin
			wr(rows[i].a, rows[i].w);
			idle(3);
			expect_reg("row", rows[i].a, rows[i].e);
		end
		$display("register rows done");
		wr(5'h12, 16'h0002);
		pulse(127, 5'h10);
		idle(2);
		check("irq fc", irq, 16'h0000);
		pulse(1, 5'h10);
		idle(2);
		check("irq fc", irq, 16'h0001);
		expect_reg("pend fc", 5'h12, 16'h0202);
		wr(5'h12, 16'h0000);
		idle(2);
		check("irq masked", irq, 16'h0000);
		wr(5'h12, 16'h0202);
		expect_reg("fc clear", 5'h12, 16'h0002);
		expect_reg("fc count", 5'h14, 16'h0080);
		expect_reg("fc cleared", 5'h14, 16'h0000);
		pulse(300, 5'h10);
		idle(2);
		expect_reg("fc sat", 5'h14, 16'h00FF);
		// Event in the same cycle as the clearing read
		@(posedge clock);
		req.addr <= 5'h14;
		req.rd <= 1'b1;
		evt <= diag_pkg::rx_evt_t'(5'h10);
		@(posedge clock);
		req.rd <= 1'b0;
		evt <= '0;
		idle(1);
		expect_reg("fc restart", 5'h14, 16'h0001);
		wr(5'h12, 16'h0200);
		$display("false carrier done");
		wr(5'h12, 16'h0001);
		pulse(10, 5'h0C);
		pulse(5, 5'h08);
		pulse(5, 5'h04);
		pulse(5, 5'h0E);
		idle(2);
		expect_reg("re count", 5'h15, 16'h000A);
		pulse(127, 5'h0C);
		idle(2);
		check("irq re", irq, 16'h0000);
		pulse(1, 5'h0C);
		idle(2);
		check("irq re", irq, 16'h0001);
		expect_reg("pend re", 5'h12, 16'h0101);
		expect_reg("re half", 5'h15, 16'h0080);
		pulse(65540, 5'h0C);
		idle(2);
		expect_reg("re sat", 5'h15, 16'hFFFF);
		wr(5'h12, 16'h0100);
		idle(2);
		check("irq re off", irq, 16'h0000);
		wr(5'h13, 16'h0001);
		pulse(1, 5'h01);
		idle(2);
		check("irq jab", irq, 16'h0001);
		expect_reg("jab", 5'h13, 16'h0101);
		wr(5'h13, 16'h0100);
		idle(2);
		check("irq jab off", irq, 16'h0000);
		$display("receive error done");
		// Checker off must never lock even on clean data
		wr(5'h16, 16'h1000);
		feed <= 1'b1;
		idle(40);
		check("tx valid", tx_prbs_valid, 16'h0001);
		expect_reg("chk off", 5'h16, 16'h1200);
		wr(5'h16, 16'h3000);
		idle(40);
		expect_reg("locked", 5'h16, 16'h3A00);
		flip <= 1'b1;
		idle(10);
		expect_reg("loss", 5'h16, 16'h3600);
		flip <= 1'b0;
		idle(30);
		expect_reg("relock", 5'h16, 16'h3A00);
		wr(5'h16, 16'h7000);
		sparse <= 1'b1;
		w0 = wraps;
		idle(5000);
		check("wrap cont", 16'(wraps != w0), 16'h0001);
		wr(5'h16, 16'h3000);
		idle(2);
		w0 = wraps;
		idle(5000);
		check("wrap single", 16'(wraps == w0), 16'h0001);
		wr(5'h16, 16'h0000);
		idle(3);
		check("tx off", tx_prbs_valid, 16'h0000);
		expect_reg("bist off", 5'h16, 16'h0000);
		$display("self test done");
		test_done();
	end
endmodule
